// ---- card_ctrl_reset_suspend.sv ----
// reset and suspend handling: output float, register clear, event context
`timescale 1ns/100ps
module card_ctrl_reset_suspend (
    input  wire logic core_clk_i,            // bus clock, 25 mhz
    input  wire logic rstn_i,                // power-on reset, active low
    input  wire logic global_reset_in_n_i,   // global reset pin, active low
    input  wire logic bus_reset_in_n_i,      // bus reset pin, active low
    input  wire logic suspend_i,             // suspend mode enable, active high
    input  wire logic event_set_i,           // power management event source
    input  wire logic event_ack_i,           // software acknowledge of the event
    output wire logic out_oe_n_o,            // output enable, high floats outputs
    output wire logic regs_clear_n_o,        // clear to internal registers
    output wire logic ctx_clear_n_o,         // clear to event context only
    output wire logic func_en_o,             // device may perform functions
    output wire logic power_mgmt_event_o,    // held event context bit
    output wire logic [1:0] state_o          // current reset state
);

    // ------------------------------------------------------------------
    // power-on reset synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // reset decode
    // ------------------------------------------------------------------
    // pins are synchronous to the bus clock, so no extra synchroniser here
    wire global_pin = ~global_reset_in_n_i;            // global reset asserted
    wire bus_pin    = ~bus_reset_in_n_i;               // bus reset asserted
    wire any_pin    = global_pin | bus_pin;            // any reset pin active
    wire global_hit = global_pin & ~suspend_i;
    wire bus_hit    = bus_pin & ~suspend_i;
    wire reg_hold   = global_hit | bus_hit;            // full register clear
    wire ctx_hold   = global_hit;

    // ------------------------------------------------------------------
    // clear lines with synchronous release
    // ------------------------------------------------------------------
    reset_release #(
        .STAGES (card_reset_pkg::RELEASE_STAGES)
    ) u_reg_release (
        .core_clk_i (core_clk_i),
        .rstn_i     (rst_sync_reg),
        .hold_i     (reg_hold),
        .clear_n_o  (regs_clear_n_o)
    );

    // bus reset leaves the event context alone so wake from deep sleep works
    reset_release #(
        .STAGES (card_reset_pkg::RELEASE_STAGES)
    ) u_ctx_release (
        .core_clk_i (core_clk_i),
        .rstn_i     (rst_sync_reg),
        .hold_i     (ctx_hold),
        .clear_n_o  (ctx_clear_n_o)
    );

    // ------------------------------------------------------------------
    // output float and function enable
    // ------------------------------------------------------------------
    // outputs float on any reset pin even under suspend
    assign out_oe_n_o = any_pin | ~regs_clear_n_o;

    card_reset_pkg::reset_state_e state_reg;
    card_reset_pkg::reset_state_e state_next;

    always_comb begin
        if (reg_hold) begin
            state_next = card_reset_pkg::ST_CLEAR;
        end else if (any_pin) begin
            state_next = card_reset_pkg::ST_SHIELD;
        end else if (!regs_clear_n_o) begin
            state_next = card_reset_pkg::ST_RELEASE;
        end else begin
            state_next = card_reset_pkg::ST_RUN;
        end
    end

    // every bus-facing flop updates on the rising bus clock edge
    always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= card_reset_pkg::ST_CLEAR;
        end else begin
            state_reg <= state_next;
        end
    end

    logic run_w;
    always_comb begin
        unique case (state_reg)
            card_reset_pkg::ST_CLEAR:   run_w = 1'b0;
            card_reset_pkg::ST_RELEASE: run_w = 1'b0;
            card_reset_pkg::ST_RUN:     run_w = 1'b1;
            card_reset_pkg::ST_SHIELD:  run_w = 1'b0;
        endcase
    end

    // state lags pins by a cycle, so gate with the live pins too
    assign func_en_o = run_w & ~any_pin & regs_clear_n_o;
    assign state_o   = state_reg;

    // ------------------------------------------------------------------
    // event context bit
    // ------------------------------------------------------------------
    // a new event wins over a same-cycle acknowledge
    logic event_reg;

    always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            event_reg <= card_reset_pkg::EVENT_CTX_RESET;
        end else if (!ctx_clear_n_o) begin
            event_reg <= card_reset_pkg::EVENT_CTX_RESET;
        end else if (event_set_i) begin
            event_reg <= 1'b1;
        end else if (event_ack_i) begin
            event_reg <= 1'b0;
        end
    end

    assign power_mgmt_event_o = event_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_global_clears: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        global_hit |=> !regs_clear_n_o && !ctx_clear_n_o)
        else $error("global reset did not clear registers");

    a_pins_float: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        any_pin |-> out_oe_n_o && !func_en_o)
        else $error("outputs driven or function active during reset");

    a_bus_keeps_ctx: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        (bus_hit && !global_hit && ctx_clear_n_o) |=> ctx_clear_n_o)
        else $error("bus reset cleared event context");

    a_bus_clears: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        bus_hit |=> !regs_clear_n_o ##0 state_reg == card_reset_pkg::ST_CLEAR)
        else $error("bus reset did not clear registers");

    a_suspend_global: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        (suspend_i && global_pin && event_reg && ctx_clear_n_o && !event_ack_i) |=> event_reg)
        else $error("global reset under suspend lost event context");

    a_suspend_bus: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        (suspend_i && bus_pin && regs_clear_n_o) |-> out_oe_n_o ##1 regs_clear_n_o)
        else $error("bus reset under suspend cleared registers");

    a_release_delay: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        reg_hold ##1 !reg_hold [*2] |=> regs_clear_n_o)
        else $error("register clear not released two cycles after reset");

    a_release_sync: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        $rose(regs_clear_n_o) |-> $past(!reg_hold) && $past(!reg_hold, 2))
        else $error("register clear released too early");

    a_run_default: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        (!any_pin && regs_clear_n_o) ##1 (!any_pin && regs_clear_n_o) |-> func_en_o)
        else $error("device not running after reset release");

    a_event_set_wins: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        (event_set_i && ctx_clear_n_o) |=> power_mgmt_event_o)
        else $error("event lost at sampling edge");

    // ------------------------------------------------------------------
    // assertion helpers and further checks
    // ------------------------------------------------------------------
    // cycles the register clear stays low once its hold has dropped;
    // a small counter keeps the check cheap instead of a long repetition
    logic [3:0] release_cnt_reg;

    always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            release_cnt_reg <= 4'h0;
        end else if (reg_hold || regs_clear_n_o) begin
            release_cnt_reg <= 4'h0;
        end else begin
            release_cnt_reg <= release_cnt_reg + 4'h1;
        end
    end

    a_release_bound: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        release_cnt_reg <= 4'(card_reset_pkg::RELEASE_STAGES))
        else $error("register clear held too long after reset");

    a_shield_state: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        (suspend_i && any_pin) |=> state_reg == card_reset_pkg::ST_SHIELD)
        else $error("reset under suspend did not enter shield state");

    a_suspend_kept: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        (suspend_i && regs_clear_n_o) |=> regs_clear_n_o)
        else $error("register clear asserted under suspend");

    a_ctx_only_global: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        $fell(ctx_clear_n_o) |-> $past(global_hit))
        else $error("event context cleared without global reset");

    a_event_ctx_clear: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        !ctx_clear_n_o |=> !power_mgmt_event_o)
        else $error("event context kept through its clear");

    a_event_ack_clears: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        (event_ack_i && !event_set_i && ctx_clear_n_o) |=> !power_mgmt_event_o)
        else $error("acknowledge did not clear event context");

    a_release_state: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        ($rose(regs_clear_n_o) && !any_pin) |=> state_reg == card_reset_pkg::ST_RUN)
        else $error("state not run after register clear released");

    a_float_clearing: assert property (@(posedge core_clk_i) disable iff (!rst_sync_reg)
        !regs_clear_n_o |-> out_oe_n_o && !func_en_o)
        else $error("outputs driven while registers clearing");

endmodule // card_ctrl_reset_suspend

// ---- card_ctrl_reset_suspend_tb.sv ----
// testbench: random resets, suspend and event traffic against a reference model
`timescale 1ns/100ps
module card_ctrl_reset_suspend_tb;
    // ------------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------------
    logic       core_clk_i, rstn_i, event_set_i, event_ack_i, susp_r;
    wire        glb_rst_n, brst_n, susp, oe_n, clr_n, ctx_n, func_en, evt;
    wire  [1:0] state;
    int         error_cnt, n_checks, cycles, exp_evt, op, len, seed;

    card_ctrl_reset_suspend dut_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .global_reset_in_n_i(glb_rst_n), .bus_reset_in_n_i(brst_n), .suspend_i(susp),
        .event_set_i(event_set_i), .event_ack_i(event_ack_i), .out_oe_n_o(oe_n),
        .regs_clear_n_o(clr_n), .ctx_clear_n_o(ctx_n), .func_en_o(func_en),
        .power_mgmt_event_o(evt), .state_o(state));
    host_reset_model host_u (.core_clk_i(core_clk_i), .global_reset_n_o(glb_rst_n),
        .bus_reset_n_o(brst_n), .suspend_o(susp));

    // clock and a hang guard well above the expected run length
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end

    // ------------------------------------------------------------------
    // compare, settle and closing tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string what);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    // release takes 2 edges plus one for enable, so 6 edges leave margin
    task automatic settle;
        repeat (6) @(posedge core_clk_i);
        #1;
        chk({1'b0, func_en}, 2'b01, "function enable");
        chk({clr_n, ctx_n}, 2'b11, "clear lines");
        chk({1'b0, oe_n}, 2'b00, "output enable");
        chk(state, 2'b10, "state");
        chk({1'b0, evt}, exp_evt[1:0], "event context");
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'h984fae82;
        {error_cnt, n_checks, cycles, exp_evt} = '0;
        {rstn_i, event_set_i, event_ack_i, susp_r} = 4'h0;
        repeat (8) @(posedge core_clk_i);
        #2 rstn_i = 1'b1;
        settle();
        repeat (60) begin
            op = $unsigned($random(seed)) % 4;
            if (op < 2) begin
                // one-cycle set or acknowledge of the event bit
                @(posedge core_clk_i) #2;
                event_set_i = (op == 0);
                event_ack_i = (op == 1);
                @(posedge core_clk_i) #2;
                event_set_i = 1'b0;
                event_ack_i = 1'b0;
                exp_evt = (op == 0);
            end else begin
                // reset pin held 5..8 cycles, with or without suspend
                susp_r = 1'($random(seed));
                len = 2 + $unsigned($random(seed)) % 4;
                host_u.assert_rst(op - 1, susp_r);
                repeat (2) @(posedge core_clk_i);
                #1;
                chk({1'b0, oe_n}, 2'b01, "outputs float");
                chk({1'b0, func_en}, 2'b00, "function off");
                chk({1'b0, clr_n}, {1'b0, susp_r}, "register clear");
                chk({1'b0, ctx_n}, {1'b0, susp_r | (op == 3)}, "context clear");
                if (susp_r) chk(state, 2'b11, "shield state");
                repeat (len) @(posedge core_clk_i);
                host_u.release_rst();
                if (op == 2 && !susp_r) exp_evt = 0;
            end
            settle();
        end
        // power-on reset again mid-run: everything, event context too, starts over
        @(posedge core_clk_i) #2 rstn_i = 1'b0;
        #1 chk({clr_n, ctx_n}, 2'b00, "clear lines in reset");
        exp_evt = 0;
        repeat (8) @(posedge core_clk_i);
        #2 rstn_i = 1'b1;
        settle();
        end_sim();
    end
endmodule // card_ctrl_reset_suspend_tb

// ---- card_reset_pkg.sv ----
// constants shared by the reset and suspend handling block
// Function
// - global reset floats all outputs and clears every register to defaults
// - later resets use bus reset so event context survives deep sleep to on
// - suspend shields registers from global reset; outputs still float
// - bus reset floats outputs, clears registers, device does nothing
// - after bus reset release the device runs from its default state
// - suspend shields registers from bus reset; outputs still float
// - every bus signal is sampled on the rising bus clock edge; the reset pins also drive out_oe_n_o and func_en_o combinationally
package card_reset_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned BUS_CLK_PERIOD_NS = 40;   // 25 mhz bus clock
    localparam int unsigned RELEASE_STAGES    = 2;    // release flops after reset

    // ------------------------------------------------------------------
    // reset values and states
    // ------------------------------------------------------------------
    localparam logic EVENT_CTX_RESET = 1'b0;        // event context after clear

    typedef enum logic [1:0] {
        ST_CLEAR   = 2'b00,                          // registers held cleared
        ST_RELEASE = 2'b01,                          // clear releasing in sync
        ST_RUN     = 2'b10,                          // normal operation
        ST_SHIELD  = 2'b11                           // reset seen under suspend
    } reset_state_e;

endpackage

// ---- host_reset_model.sv ----
// host system model: drives the reset pins and the suspend enable
`timescale 1ns/100ps
module host_reset_model #(
    parameter bit WAKE_CAPABLE = 1'b0          // host supports wake from deep sleep
) (
    input  wire logic core_clk_i,              // bus clock
    output logic      global_reset_n_o,        // global reset pin, active low
    output logic      bus_reset_n_o,           // bus reset pin, active low
    output logic      suspend_o                // suspend enable, active high
);
    // ------------------------------------------------------------------
    // pin driving
    // ------------------------------------------------------------------
    logic booted;                              // first reset already given
    initial begin
        global_reset_n_o = 1'b1;
        bus_reset_n_o    = 1'b1;
        suspend_o        = 1'b0;
        booted           = 1'b0;
    end
    // kind 1 global, 2 bus; pins move just after the rising edge only
    task automatic assert_rst(input int kind, input bit susp);
        bit use_global;
        use_global = (kind == 1) && !(WAKE_CAPABLE && booted);
        @(posedge core_clk_i) #2;
        suspend_o = susp;
        if (use_global) global_reset_n_o = 1'b0;
        else bus_reset_n_o = 1'b0;
    endtask
    // suspend is dropped one edge after the pins so it covers the release
    task automatic release_rst;
        @(posedge core_clk_i) #2;
        global_reset_n_o = 1'b1;
        bus_reset_n_o    = 1'b1;
        booted           = 1'b1;
        @(posedge core_clk_i) #2;
        suspend_o = 1'b0;
    endtask
endmodule // host_reset_model

// ---- reset_release.sv ----
// one clear line: asserted at once, released after a synchronous delay
`timescale 1ns/100ps
module reset_release #(
    parameter int unsigned STAGES = card_reset_pkg::RELEASE_STAGES
) (
    input  wire logic core_clk_i,   // bus clock
    input  wire logic rstn_i,       // synchronised reset, active low
    input  wire logic hold_i,       // keep clear asserted
    output wire logic clear_n_o     // clear, active low
);

    logic [STAGES-1:0] shift_reg;

    // ------------------------------------------------------------------
    // release shift
    // ------------------------------------------------------------------
    // assertion is immediate at the edge; release walks through the stages
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_reg <= '0;
        end else if (hold_i) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= {shift_reg[STAGES-2:0], 1'b1};
        end
    end

    assign clear_n_o = shift_reg[STAGES-1];

endmodule // reset_release
